// ==== core/cha_consts.svh ====
// Offsets, field positions, reset values and codes of the command and host access registers
`ifndef CHA_CONSTS_SVH
`define CHA_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CHA_OFF_COMMAND_CONTROL 8'h00
`define CHA_OFF_HOST_ACCESS_CONTROL 8'h01

// ****************************************************************
// Command control fields
// ****************************************************************
`define CHA_CMD_STANDBY_BIT 7
`define CHA_CMD_RF_OFF_BIT 6
`define CHA_CMD_CODE_MSB 4
`define CHA_CMD_CODE_LSB 0
`define CHA_CMD_IDLE_CODE 5'h00
`define CHA_CMD_RESET 8'h00

// ****************************************************************
// Host access control fields
// ****************************************************************
`define CHA_HAC_UNLOCK_BIT 7
`define CHA_HAC_OWN_HOST_BIT 6
`define CHA_HAC_OWN_SECURE_BIT 5
`define CHA_HAC_PORT_MSB 3
`define CHA_HAC_PORT_LSB 2
`define CHA_HAC_RESET 8'h00

// ****************************************************************
// Answer for unmapped offsets
// ****************************************************************
`define CHA_UNMAPPED_DATA 8'h00

`endif

// ==== core/cha_host_access.sv ====
// Host access control register with its write-once unlock step
`timescale 1ns/1ps
`include "cha_consts.svh"

module cha_host_access
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic any_wr,
    input wire logic hac_wr,
    input wire logic [7:0] wdata,
    output cha_pkg::cha_hac_s state
);

    cha_pkg::cha_hac_s hac_q;
    cha_pkg::cha_hac_s hac_d;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Any write while unlocked consumes the unlock; a write to this register also applies the fields
    always_comb
    begin
        hac_d = hac_q;
        if (any_wr && hac_q.host_access_unlock)
        begin
            hac_d.host_access_unlock = 1'b0;
            if (hac_wr)
            begin
                // Both owners at once is refused, the old owner stays
                if (!(wdata[`CHA_HAC_OWN_HOST_BIT] && wdata[`CHA_HAC_OWN_SECURE_BIT]))
                begin
                    hac_d.bus_owner_host = wdata[`CHA_HAC_OWN_HOST_BIT];
                    hac_d.bus_owner_secure_module = wdata[`CHA_HAC_OWN_SECURE_BIT];
                end
                hac_d.secure_module_port_select =
                    cha_pkg::cha_port_e'(wdata[`CHA_HAC_PORT_MSB:`CHA_HAC_PORT_LSB]);
            end
        end
        else if (hac_wr)
        begin
            // Locked: only the unlock bit is taken, the rest is ignored
            hac_d.host_access_unlock = wdata[`CHA_HAC_UNLOCK_BIT];
        end
    end

    // State register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hac_q <= cha_pkg::cha_hac_s'(5'h00);
        end
        else
        begin
            hac_q <= hac_d;
        end
    end

    assign state = hac_q;

endmodule : cha_host_access

// ==== core/cha_pkg.sv ====
// Types shared by the command and host access register bank
package cha_pkg;

    // Interface selection of the secure module port
    typedef enum logic [1:0]
    {
        CHA_PORT_OFF,
        CHA_PORT_SPI,
        CHA_PORT_I2C_LIGHT_VARIANT,
        CHA_PORT_I2C
    } cha_port_e;

    // State of the host access control register
    typedef struct packed
    {
        logic host_access_unlock;
        logic bus_owner_host;
        logic bus_owner_secure_module;
        cha_port_e secure_module_port_select;
    } cha_hac_s;

    // State of the top level bank
    typedef struct packed
    {
        logic standby;
        logic rf_frontend_off;
        logic [4:0] cmd_code;
        logic cmd_start;
        logic [7:0] rdata;
        logic rvalid;
    } cha_main_s;

endpackage : cha_pkg

// ==== core/cha_regs.sv ====
// Command and host access register bank of the reader front end
`timescale 1ns/1ps
`include "cha_consts.svh"

// What this block does
// - Writing one to bit 7 of command_control puts the device into power-down.
// - Writing one to bit 6 of command_control powers down the RF receiver and transmitter.
// - Bits 4 to 0 of command_control hold the running command, and writing them selects the command.
// - The command field returns to the idle code by itself when the running command finishes.
// - Setting bit 7 of host_access_control unlocks the rest of it for the next write.
// - The unlock bit clears itself on the next write access after it was set.
// - Bit 6 of host_access_control hands the internal bus to the host.
// - Bit 5 of host_access_control hands the internal bus to the secure module.
// - Both ownership bits never stand set together; a write asking for both keeps the old owners, but its port field is still taken.
// - Ownership bits are taken only when the unlock bit was set before.
// - Bits 3 to 2 of host_access_control select the secure module port: off, SPI, I2C light, I2C.
module cha_regs
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic cmd_done,
    input wire logic wake_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [4:0] cmd_code,
    output logic cmd_start,
    output logic power_down,
    output logic rf_frontend_off,
    output logic host_access_unlock,
    output logic bus_owner_host,
    output logic bus_owner_secure_module,
    output cha_pkg::cha_port_e secure_module_port_select
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The offsets need at least a full byte of address
    if (ADDR_W < 8)
    begin : g_bad_addr_w
        $error("cha_regs: ADDR_W must be at least 8");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    cha_pkg::cha_main_s main_q;
    cha_pkg::cha_main_s main_d;
    cha_pkg::cha_hac_s hac;
    logic sel_cmd;
    logic sel_hac;
    logic [7:0] cmd_view;
    logic [7:0] hac_view;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Upper address bits must be zero for a hit
    assign sel_cmd = (reg_addr == ADDR_W'(`CHA_OFF_COMMAND_CONTROL));
    assign sel_hac = (reg_addr == ADDR_W'(`CHA_OFF_HOST_ACCESS_CONTROL));

    // ****************************************************************
    // Host access control register
    // ****************************************************************
    // Every write, to any offset, is shown so the unlock can be consumed
    cha_host_access u_host_access
    (
        .clock(clock),
        .resetn(resetn),
        .any_wr(reg_wr),
        .hac_wr(reg_wr && sel_hac),
        .wdata(reg_wdata),
        .state(hac)
    );

    // ****************************************************************
    // Read views
    // ****************************************************************
    // Reserved bits are tied to zero in both views
    always_comb
    begin
        cmd_view = 8'h00;
        cmd_view[`CHA_CMD_STANDBY_BIT] = main_q.standby;
        cmd_view[`CHA_CMD_RF_OFF_BIT] = main_q.rf_frontend_off;
        cmd_view[`CHA_CMD_CODE_MSB:`CHA_CMD_CODE_LSB] = main_q.cmd_code;
        hac_view = 8'h00;
        hac_view[`CHA_HAC_UNLOCK_BIT] = hac.host_access_unlock;
        hac_view[`CHA_HAC_OWN_HOST_BIT] = hac.bus_owner_host;
        hac_view[`CHA_HAC_OWN_SECURE_BIT] = hac.bus_owner_secure_module;
        hac_view[`CHA_HAC_PORT_MSB:`CHA_HAC_PORT_LSB] = hac.secure_module_port_select;
    end

    // ****************************************************************
    // Next state of the command register and read port
    // ****************************************************************
    // A host write beats a finish or wake event in the same cycle
    always_comb
    begin
        main_d = main_q;
        main_d.cmd_start = 1'b0;
        main_d.rvalid = 1'b0;

        // The running command ends and the field falls back to idle
        if (cmd_done)
        begin
            main_d.cmd_code = `CHA_CMD_IDLE_CODE;
        end

        // Wake-up from power-down is reported by the power logic
        if (wake_req)
        begin
            main_d.standby = 1'b0;
        end

        // Host write to the command register
        if (reg_wr && sel_cmd)
        begin
            main_d.standby = reg_wdata[`CHA_CMD_STANDBY_BIT];
            main_d.rf_frontend_off = reg_wdata[`CHA_CMD_RF_OFF_BIT];
            main_d.cmd_code = reg_wdata[`CHA_CMD_CODE_MSB:`CHA_CMD_CODE_LSB];
            main_d.cmd_start = 1'b1;
        end

        // Read answer one cycle after the strobe
        if (reg_rd)
        begin
            main_d.rvalid = 1'b1;
            if (sel_cmd)
            begin
                main_d.rdata = cmd_view;
            end
            else if (sel_hac)
            begin
                main_d.rdata = hac_view;
            end
            else
            begin
                main_d.rdata = `CHA_UNMAPPED_DATA;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            main_q <= '0;
        end
        else
        begin
            main_q <= main_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // All outputs are taken straight from flip-flops
    assign reg_rdata = main_q.rdata;
    assign reg_rvalid = main_q.rvalid;
    assign cmd_code = main_q.cmd_code;
    assign cmd_start = main_q.cmd_start;
    assign power_down = main_q.standby;
    assign rf_frontend_off = main_q.rf_frontend_off;
    assign host_access_unlock = hac.host_access_unlock;
    assign bus_owner_host = hac.bus_owner_host;
    assign bus_owner_secure_module = hac.bus_owner_secure_module;
    assign secure_module_port_select = hac.secure_module_port_select;

endmodule : cha_regs

// ==== dv/cha_engine_model.sv ====
// Command engine and power logic model driving completion and wake pulses
`timescale 1ns/1ps
module cha_engine_model
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic cmd_start,
    input wire logic [4:0] cmd_code,
    input wire logic slow,
    input wire logic wake,
    output logic cmd_done,
    output logic wake_req
);
    logic [3:0] cnt_q;
    // Runs a started command for a short or long time, then reports it finished
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= 4'h0;
            cmd_done <= 1'b0;
            wake_req <= 1'b0;
        end
        else
        begin
            wake_req <= wake;
            cmd_done <= cnt_q == 4'h1;
            if (cmd_start && cmd_code != 5'h00)
                cnt_q <= slow ? 4'hc : 4'h1;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule : cha_engine_model

// ==== dv/cha_regs_monitor.sv ====
// Port assertions of the command and host access register bank
`timescale 1ns/1ps
module cha_regs_monitor
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic cmd_done,
    input wire logic wake_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [4:0] cmd_code,
    input wire logic cmd_start,
    input wire logic power_down,
    input wire logic rf_frontend_off,
    input wire logic host_access_unlock,
    input wire logic bus_owner_host,
    input wire logic bus_owner_secure_module,
    input wire cha_pkg::cha_port_e secure_module_port_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Decoded writes and register views
    wire logic cw = reg_wr && reg_addr == ADDR_W'(0);
    wire logic hw = reg_wr && reg_addr == ADDR_W'(1);
    wire logic [1:0] own = {bus_owner_host, bus_owner_secure_module};
    wire logic [3:0] hst = {own, secure_module_port_select};
    wire logic [7:0] rview = reg_addr == ADDR_W'(0) ? {power_down, rf_frontend_off, 1'b0, cmd_code}
        : reg_addr == ADDR_W'(1) ? {host_access_unlock, own, 1'b0, secure_module_port_select, 2'b00} : 8'h00;
    sequence s_open_write;
        host_access_unlock && hw;
    endsequence
    AST_STANDBY:
        assert property (cw |=> power_down == $past(reg_wdata[7])) else $error("standby bit wrong");
    AST_RF_OFF:
        assert property (cw |=> rf_frontend_off == $past(reg_wdata[6])) else $error("rf off bit wrong");
    AST_CMD_WRITE:
        assert property (cw |=> cmd_start && cmd_code == $past(reg_wdata[4:0])) else $error("command not taken");
    AST_CMD_DONE:
        assert property (cmd_done && !cw |=> cmd_code == 5'h00) else $error("command not cleared");
    AST_WAKE:
        assert property (wake_req && !cw |=> !power_down) else $error("standby not cleared by wake");
    AST_UNLOCK_SET:
        assert property (!host_access_unlock && hw |=> host_access_unlock == $past(reg_wdata[7])) else $error("unlock");
    AST_UNLOCK_CLEAR:
        assert property (host_access_unlock && reg_wr |=> !host_access_unlock) else $error("unlock not cleared");
    AST_GRANT:
        assert property (s_open_write ##0 !(reg_wdata[6] && reg_wdata[5])
            |=> hst == {$past(reg_wdata[6:5]), $past(reg_wdata[3:2])})
        else $error("fields not taken");
    AST_BOTH_REFUSED:
        assert property (s_open_write ##0 (reg_wdata[6] && reg_wdata[5]) |=> own == $past(own)) else $error("both taken");
    AST_NEVER_BOTH:
        assert property (!(bus_owner_host && bus_owner_secure_module)) else $error("two bus owners");
    AST_LOCKED_HOLD:
        assert property (!host_access_unlock && hw |=> hst == $past(hst)) else $error("locked write taken");
    AST_READ_VIEW:
        assert property (reg_rd |=> reg_rvalid && reg_rdata == $past(rview)) else $error("read data wrong");
endmodule : cha_regs_monitor
bind cha_regs cha_regs_monitor #(.ADDR_W(ADDR_W)) i_mon (.clock(clock), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_done(cmd_done), .wake_req(wake_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cmd_code(cmd_code), .cmd_start(cmd_start),
    .power_down(power_down), .rf_frontend_off(rf_frontend_off), .host_access_unlock(host_access_unlock),
    .bus_owner_host(bus_owner_host), .bus_owner_secure_module(bus_owner_secure_module),
    .secure_module_port_select(secure_module_port_select));

// ==== dv/command_and_host_access_regs_test.sv ====
// Self-checking bench of the command and host access register bank
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("wrong value at %0t: %h", $time, a); end end
module command_and_host_access_regs_test;
    logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, slow = 0, wake = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, h;
    logic [4:0] cmd_code;
    logic reg_rvalid, cmd_start, power_down, rf_frontend_off, cmd_done, wake_req;
    logic host_access_unlock, bus_owner_host, bus_owner_secure_module;
    cha_pkg::cha_port_e secure_module_port_select;
    logic [7:0] q[$];
    int fails = 0, checked = 0;
    int unsigned seed = 3;
    cha_regs i_dut (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .cmd_done(cmd_done), .wake_req(wake_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .cmd_code(cmd_code), .cmd_start(cmd_start), .power_down(power_down),
        .rf_frontend_off(rf_frontend_off), .host_access_unlock(host_access_unlock),
        .bus_owner_host(bus_owner_host), .bus_owner_secure_module(bus_owner_secure_module),
        .secure_module_port_select(secure_module_port_select));
    cha_engine_model i_eng (.clock(clock), .resetn(resetn), .cmd_start(cmd_start), .cmd_code(cmd_code),
        .slow(slow), .wake(wake), .cmd_done(cmd_done), .wake_req(wake_req));
    // Clock at 50 MHz
    initial forever #10 clock = ~clock;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        q.push_back(e);
        @(posedge clock);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
    endtask : rd
    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // Compares each read answer with the oldest expected value
    always @(posedge clock)
        if (reg_rvalid === 1'b1)
            `CHK(reg_rdata, q.pop_front())
    // Cuts a hang short
    initial
    begin
        repeat (3000) @(posedge clock);
        fails++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        resetn <= 1;
        rd(0, 8'h00);
        rd(1, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            slow <= i[0];
            d = rnd() | {i[1], 7'h01};
            wr(0, d);
            if (i[0]) rd(0, d & 8'hdf);
            for (int k = 0; k < 40 && cmd_done !== 1'b1; k++) @(posedge clock);
            rd(0, d & 8'hc0);
            `CHK({power_down, rf_frontend_off, cmd_code}, {d[7:6], 5'h00})
            wake <= 1;
            @(posedge clock);
            wake <= 0;
            rd(0, d & 8'h40);
        end
        $display("command test done");
        wr(1, 8'h6c);
        rd(1, 8'h00);
        h = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            wr(1, 8'h80);
            rd(1, 8'h80 | h);
            d = {1'b0, ~i[0], i[0], 5'(rnd() & 8'h13)} | {4'h0, i[1:0], 2'h0};
            wr(1, d);
            h = d & 8'h6c;
            rd(1, h);
            `CHK({bus_owner_host, bus_owner_secure_module, secure_module_port_select}, {h[6:5], h[3:2]})
        end
        $display("ownership test done");
        wr(1, 8'h80);
        wr(1, 8'he4);
        h = (h & 8'h60) | 8'h04;
        rd(1, h);
        wr(1, 8'h80);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        wr(1, 8'h40);
        rd(1, h);
        repeat (3) @(posedge clock);
        `CHK(q.size(), 0)
        $display("refusal test done");
        stop_test();
    end
endmodule : command_and_host_access_regs_test
